// ### hw/scs_clock_select.sv
// clock source select and internal oscillator frequency control
`timescale 1ns/1ps
`default_nettype none
`include "scs_map.svh"
module scs_clock_select
  import scs_pkg::*;
#(
  parameter logic [10:0] OST_CYCLES = `SCS_OST_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] config_mode,
  input wire logic pll_enable_fuse,
  input wire logic wake_event,
  input wire logic osc_in_pin_i,
  input wire logic hf_src_tick,
  input wire logic lf_src_tick,
  input wire logic ext_src_tick,
  input wire logic osc_lock_status,
  input wire logic osc_stable_status,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic sys_clk_tick,
  output logic sys_clk_src_int,
  output logic [1:0] amp_gain,
  output logic device_hold_reset,
  output logic osc_out_pin_o,
  output logic osc_out_pin_oe,
  output logic osc_in_pin_gpio,
  output logic osc_out_pin_gpio
);
  typedef struct packed {
    scs_state_t state;
    logic [2:0] mode;
    logic pll_en;
    logic [1:0] int_freq_select;
    logic [10:0] ost_cnt;
    logic in_prev;
    logic clkout;
    logic [7:0] rdata;
  } scs_st_t;
  scs_st_t st_ff, nxt_st;

  logic int_mode;
  logic resonator_mode;
  logic clkout_mode;
  logic src_tick;
  logic div_tick;
  logic quarter_tick;
  logic in_rise;

  // mode decode from the captured configuration
  always_comb begin
    int_mode = (st_ff.mode == `SCS_MODE_INTIO) || (st_ff.mode == `SCS_MODE_INTCLK);
    resonator_mode = (st_ff.mode == `SCS_MODE_LP) || (st_ff.mode == `SCS_MODE_XT) ||
      (st_ff.mode == `SCS_MODE_HS); // [RULE7]
    clkout_mode = (st_ff.mode == `SCS_MODE_RC) || (st_ff.mode == `SCS_MODE_INTCLK); // [RULE2] [RULE4]
  end

  // internal source is either the pll output or the precision source
  always_comb begin
    if (int_mode) begin
      src_tick = st_ff.pll_en ? hf_src_tick : lf_src_tick; // [RULE8] [RULE9]
    end else begin
      src_tick = ext_src_tick; // [RULE2] [RULE6]
    end
  end

  // shared divider: the select field only moves the tap, so no restart gap
  scs_postscaler u_post (
    .clk(clk),
    .resetn(resetn),
    .src_tick(src_tick),
    .freq_sel(int_mode ? st_ff.int_freq_select : 2'h3),
    .div_tick(div_tick),
    .quarter_tick(quarter_tick)
  ); // [RULE10] [RULE11] [RULE13]

  assign in_rise = osc_in_pin_i & ~st_ff.in_prev;

  // main next-state logic
  always_comb begin
    nxt_st = st_ff;
    nxt_st.in_prev = osc_in_pin_i;
    nxt_st.rdata = 8'h00;
    if (quarter_tick) begin
      nxt_st.clkout = ~st_ff.clkout; // toggles every second system tick
    end
    unique case (st_ff.state)
      SCS_ST_CAPTURE: begin
        // fuses sampled once after reset release, held afterwards
        nxt_st.mode = config_mode; // [RULE1] [RULE20]
        nxt_st.pll_en = pll_enable_fuse; // [RULE20]
        nxt_st.ost_cnt = 11'h000;
        nxt_st.state = SCS_ST_STARTUP;
      end
      SCS_ST_STARTUP: begin
        if (!resonator_mode) begin
          nxt_st.state = SCS_ST_RUN; // [RULE18]
        end else if (in_rise) begin
          nxt_st.ost_cnt = st_ff.ost_cnt + 11'h001;
          if (st_ff.ost_cnt + 11'h001 == OST_CYCLES) begin
            nxt_st.state = SCS_ST_RUN; // [RULE17]
          end
        end
      end
      SCS_ST_RUN: begin
        if (wake_event && resonator_mode) begin
          nxt_st.ost_cnt = 11'h000;
          nxt_st.state = SCS_ST_STARTUP; // [RULE17]
        end
      end
    endcase
    // register writes: only the select field is writable
    if (reg_wr && reg_addr == `SCS_ADDR_OSC_CTRL) begin
      nxt_st.int_freq_select = reg_wdata[`SCS_FSEL_HI:`SCS_FSEL_LO]; // [RULE16]
    end
    // read data stand one cycle after the strobe; unmapped reads zero
    if (reg_rd) begin
      unique case (reg_addr)
        `SCS_ADDR_OSC_CTRL: begin
          nxt_st.rdata[`SCS_FSEL_HI:`SCS_FSEL_LO] = st_ff.int_freq_select; // [RULE16]
          nxt_st.rdata[`SCS_LOCK_BIT] = osc_lock_status; // [RULE14] [RULE19]
          nxt_st.rdata[`SCS_STABLE_BIT] = osc_stable_status; // [RULE15] [RULE19]
        end
        `SCS_ADDR_MODE_STAT: begin
          nxt_st.rdata[2:0] = st_ff.mode;
          nxt_st.rdata[3] = st_ff.pll_en;
          nxt_st.rdata[4] = (st_ff.state == SCS_ST_RUN);
        end
        default: begin
          nxt_st.rdata = 8'h00;
        end
      endcase
    end
  end

  // every reset restores the default divider
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_ff <= '0;
      st_ff.state <= SCS_ST_CAPTURE;
      st_ff.int_freq_select <= `SCS_FSEL_RESET; // [RULE12]
    end else begin
      st_ff <= nxt_st;
    end
  end

  // pin and clock outputs
  always_comb begin
    osc_in_pin_gpio = int_mode; // [RULE4] [RULE5]
    osc_out_pin_gpio = !clkout_mode && !resonator_mode; // [RULE3] [RULE5] [RULE6]
    osc_out_pin_oe = clkout_mode; // [RULE2] [RULE4]
    osc_out_pin_o = clkout_mode & st_ff.clkout;
    sys_clk_src_int = int_mode ? `SCS_SRC_INT : `SCS_SRC_EXT;
    unique case (st_ff.mode)
      `SCS_MODE_HS: amp_gain = `SCS_GAIN_HIGH; // [RULE7]
      `SCS_MODE_XT: amp_gain = `SCS_GAIN_MID;
      `SCS_MODE_LP: amp_gain = `SCS_GAIN_LOW;
      default: amp_gain = `SCS_GAIN_NONE;
    endcase
    device_hold_reset = (st_ff.state != SCS_ST_RUN); // [RULE17]
    sys_clk_tick = div_tick & (st_ff.state == SCS_ST_RUN);
    reg_rdata = st_ff.rdata;
  end
endmodule
`default_nettype wire

// ### hw/scs_map.svh
// constants, field layouts and encodings of the clock source select block
// Summary of operation
// RULE1: three-bit mode field picks one of eight clock source modes, fixed at programming.
// RULE2: rc mode clocks from rc on input pin, drives clock/4 on output pin.
// RULE3: rc pins-free variant releases output pin as general purpose io.
// RULE4: internal with clkout frees input pin, drives internal clock/4 on output pin.
// RULE5: internal pins-free mode releases both oscillator pins as general io.
// RULE6: external clock mode takes logic clock on input pin, frees output pin.
// RULE7: three resonator modes select high, medium and low amplifier gain.
// RULE8: internal clock is 500 kHz source with postscaler 1, 2, 4 or 8.
// RULE9: pll fuse raises source to 16 MHz ahead of postscaler, fixed set.
// RULE10: pll set: codes 11,10,01,00 give 16, 8, 4, 2 MHz.
// RULE11: pll clear: codes 11,10,01,00 give 500, 250, 125, 62.5 kHz.
// RULE12: every reset loads frequency select with 10; software may change later.
// RULE13: new frequency selection takes effect with no start-up delay.
// RULE14: read-only lock flag reads 1 once high-frequency source locked within 2%.
// RULE15: read-only stable flag reads 1 once source reaches 0.5% accuracy.
// RULE16: control bits 7-6 and 1-0 read zero; select field bits 5-4 read/write.
// RULE17: resonator modes hold reset until 1024 input pin cycles counted.
// RULE18: external clock mode disables start-up counter, no delay after reset.
// RULE19: lock and stable flags come from oscillator model status inputs.
// RULE20: mode and pll fuse sampled at reset and held while running.
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH
`define SCS_ADDR_OSC_CTRL 4'h0
`define SCS_ADDR_MODE_STAT 4'h1
`define SCS_FSEL_HI 5
`define SCS_FSEL_LO 4
`define SCS_LOCK_BIT 3
`define SCS_STABLE_BIT 2
`define SCS_FSEL_RESET 2'h2
`define SCS_OST_CYCLES 11'h400
`define SCS_MODE_LP 3'h0
`define SCS_MODE_XT 3'h1
`define SCS_MODE_HS 3'h2
`define SCS_MODE_EC 3'h3
`define SCS_MODE_INTIO 3'h4
`define SCS_MODE_INTCLK 3'h5
`define SCS_MODE_RESISTOR_CAP_PINS_FREE 3'h6
`define SCS_MODE_RC 3'h7
`define SCS_GAIN_NONE 2'h0
`define SCS_GAIN_LOW 2'h1
`define SCS_GAIN_MID 2'h2
`define SCS_GAIN_HIGH 2'h3
`define SCS_SRC_EXT 1'h0
`define SCS_SRC_INT 1'h1
`endif

// ### hw/scs_pkg.sv
// types shared by the clock source select block
package scs_pkg;
  typedef enum logic [1:0] {
    SCS_ST_CAPTURE,
    SCS_ST_STARTUP,
    SCS_ST_RUN
  } scs_state_t;
endpackage

// ### hw/scs_postscaler.sv
// divide-by-1/2/4/8 postscaler with a free-running counter, plus quarter clock
`timescale 1ns/1ps
`default_nettype none
module scs_postscaler
  import scs_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic src_tick,
  input wire logic [1:0] freq_sel,
  output logic div_tick,
  output logic quarter_tick
);
  typedef struct packed {
    logic [2:0] cnt;
    logic qcnt; // half phase of the clock-out divider
  } scs_ps_st_t;
  scs_ps_st_t st_ff, nxt_st;
  logic sel_tick;

  // tap the shared counter so a new selection applies on the very next tick
  always_comb begin
    unique case (freq_sel)
      2'h3: sel_tick = src_tick;
      2'h2: sel_tick = src_tick & st_ff.cnt[0];
      2'h1: sel_tick = src_tick & (&st_ff.cnt[1:0]);
      2'h0: sel_tick = src_tick & (&st_ff.cnt);
    endcase
  end

  // next state: counters advance only on source ticks
  always_comb begin
    nxt_st = st_ff;
    if (src_tick) begin
      nxt_st.cnt = st_ff.cnt + 3'h1;
    end
    if (sel_tick) begin
      nxt_st.qcnt = ~st_ff.qcnt;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign div_tick = sel_tick;
  // toggle every second tick: full clock-out period is four system ticks
  assign quarter_tick = sel_tick & st_ff.qcnt;
endmodule
`default_nettype wire

// ### tb/scs_osc_model.sv
// behavioural oscillator sources and status levels
`timescale 1ns/1ps
`default_nettype none
module scs_osc_model (
  input wire logic clk,
  input wire logic resetn,
  output logic hf_src_tick,
  output logic lf_src_tick,
  output logic ext_src_tick,
  output logic osc_in_pin_i,
  output logic osc_lock_status,
  output logic osc_stable_status
);
  logic [1:0] ph_ff = 2'h0;
  logic [5:0] age_ff = 6'h0;
  // sources run free; status settles a while after reset
  always_ff @(posedge clk) begin
    ph_ff <= ph_ff + 2'h1;
    age_ff <= !resetn ? 6'h0 : age_ff + {5'h0, age_ff != 6'h3f};
  end
  assign hf_src_tick = ph_ff[0];
  assign lf_src_tick = ph_ff == 2'h3;
  assign ext_src_tick = ph_ff[0];
  assign osc_in_pin_i = ph_ff[1]; // resonator swing
  assign osc_lock_status = age_ff >= 6'h18;
  assign osc_stable_status = age_ff >= 6'h28;
endmodule
`default_nettype wire

// ### tb/scs_clock_select_props.sv
// assertion checker for the clock source select block
`timescale 1ns/1ps
`default_nettype none
module scs_clock_select_props #(
  parameter logic [10:0] OST_CYCLES = 11'h400
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic osc_lock_status,
  input wire logic osc_stable_status,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic sys_clk_src_int,
  input wire logic [1:0] amp_gain,
  input wire logic osc_out_pin_oe,
  input wire logic osc_in_pin_gpio,
  input wire logic osc_out_pin_gpio,
  input wire logic device_hold_reset
);
  logic rd0_ff, wr0_ff, lock_ff, stab_ff;
  logic [1:0] wsel_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // one cycle of bus and status history
  always_ff @(posedge clk) begin
    rd0_ff <= resetn && reg_rd && reg_addr == 4'h0;
    wr0_ff <= resetn && reg_wr && reg_addr == 4'h0;
    lock_ff <= osc_lock_status;
    stab_ff <= osc_stable_status;
    wsel_ff <= reg_wdata[5:4];
  end
  a_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h0)
    else $error("idle read data");
  a_ctrl_layout: assert property (rd0_ff |-> {reg_rdata[7:6], reg_rdata[1:0]} == 4'h0)
    else $error("unused bits set");
  a_status_mirror: assert property (rd0_ff |-> reg_rdata[3:2] == {lock_ff, stab_ff})
    else $error("status bits wrong");
  a_write_applies: assert property (wr0_ff ##1 rd0_ff |-> reg_rdata[5:4] == $past(wsel_ff))
    else $error("select not written");
  a_reset_sel: assert property ($rose(resetn) ##2 rd0_ff |-> reg_rdata[5:4] == 2'h2)
    else $error("select reset value");
  a_gain_ext: assert property (amp_gain != 2'h0 |-> !sys_clk_src_int && !osc_out_pin_oe)
    else $error("gain outside resonator");
  a_clkout_pin: assert property (osc_out_pin_oe |-> !osc_out_pin_gpio)
    else $error("clkout pin freed");
  a_int_in_free: assert property (sys_clk_src_int |-> osc_in_pin_gpio)
    else $error("input pin held");
  c_read_back: cover property (wr0_ff ##1 rd0_ff);
  c_hold_release: cover property ($fell(device_hold_reset));
  c_clkout: cover property (osc_out_pin_oe && sys_clk_src_int);
endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the clock source select block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import scs_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, pll_enable_fuse = 1'b0, wake_event = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic [2:0] config_mode = 3'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h0, d, reg_rdata;
  logic hf_src_tick, lf_src_tick, ext_src_tick, osc_in_pin_i, osc_lock_status;
  logic osc_stable_status, sys_clk_tick, sys_clk_src_int, device_hold_reset, osc_out_pin_o;
  logic osc_out_pin_oe, osc_in_pin_gpio, osc_out_pin_gpio;
  logic [1:0] amp_gain;
  logic [7:0] exp_q[$];
  int error_cnt = 0, compares = 0, n, t;
  always #20 clk = ~clk;
  scs_osc_model i_osc (.clk, .resetn, .hf_src_tick, .lf_src_tick, .ext_src_tick,
    .osc_in_pin_i, .osc_lock_status, .osc_stable_status);
  scs_clock_select #(.OST_CYCLES(11'h4)) i_dut (.clk, .resetn, .config_mode, .pll_enable_fuse,
    .wake_event, .osc_in_pin_i, .hf_src_tick, .lf_src_tick, .ext_src_tick, .osc_lock_status,
    .osc_stable_status, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sys_clk_tick,
    .sys_clk_src_int, .amp_gain, .device_hold_reset, .osc_out_pin_o, .osc_out_pin_oe,
    .osc_in_pin_gpio, .osc_out_pin_gpio);
  // tolerance covers divider phase at window edges
  task automatic chk(input logic [7:0] e, input logic [7:0] g, input int tol);
    compares++;
    if (g !== e && !(tol > 0 && g + tol >= e && g <= e + tol)) begin
      error_cnt++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic bus(input logic w, r, input logic [3:0] a, input logic [7:0] wd, e);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= wd;
    if (r) exp_q.push_back(e);
    @(posedge clk);
  endtask
  task automatic idle(input int k);
    bus(1'b0, 1'b0, 4'h0, 8'h0, 8'h0);
    repeat (k) @(posedge clk);
  endtask
  task automatic do_reset(input logic [2:0] m, input logic p);
    resetn <= 1'b0;
    config_mode <= m;
    pll_enable_fuse <= p;
    idle(2);
    resetn <= 1'b1;
  endtask
  task automatic pins(input logic [2:0] m, input logic h);
    logic [1:0] g;
    g = (m == 3'h2) ? 2'h3 : (m == 3'h1) ? 2'h2 : {1'b0, m == 3'h0};
    @(negedge clk);
    chk({1'b0, h, g, m == 3'h5 || m == 3'h7, m[2] && !m[1], m == 3'h3 || m == 3'h4 || m == 3'h6,
      m[2] && !m[1]}, {1'b0, device_hold_reset, amp_gain, osc_out_pin_oe, osc_in_pin_gpio,
      osc_out_pin_gpio, sys_clk_src_int}, 0);
    @(posedge clk);
  endtask
  task automatic end_sim;
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // read answers land one cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) chk(exp_q.pop_front(), reg_rdata, 0);
    rd_d <= reg_rd;
  end
  initial begin
    #(40 * 20000);
    error_cnt++;
    end_sim();
  end
  initial begin
    void'($urandom(13327));
    do_reset(3'h5, 1'b1);
    idle(0);
    bus(1'b0, 1'b1, 4'h0, 8'h0, 8'h20);
    repeat (4) begin
      d = $urandom;
      bus(1'b1, 1'b0, 4'h0, d, 8'h0);
      bus(1'b0, 1'b1, 4'h0, 8'h0, {2'h0, d[5:4], 4'h0});
    end
    bus(1'b1, 1'b0, 4'h1, 8'hff, 8'h0);
    bus(1'b0, 1'b1, 4'h1, 8'h0, 8'h1d);
    bus(1'b0, 1'b1, 4'h9, 8'h0, 8'h0);
    idle(50);
    bus(1'b0, 1'b1, 4'h0, 8'h0, {2'h0, d[5:4], 4'hc});
    // divider ratios and clock-out rate for both fuse sets
    for (int p = 0; p < 2; p++) begin
      do_reset(3'h5, p[0]);
      idle(4);
      for (int s = 0; s < 4; s++) begin
        bus(1'b1, 1'b0, 4'h0, {2'h0, s[1:0], 4'h0}, 8'h0);
        idle(4);
        n = 0;
        t = 0;
        d[0] = osc_out_pin_o;
        repeat (128) begin
          @(negedge clk);
          n += int'(sys_clk_tick);
          t += int'(osc_out_pin_o != d[0]);
          d[0] = osc_out_pin_o;
        end
        @(posedge clk);
        chk(8'((p ? 64 : 32) >> (3 - s)), 8'(n), 1);
        chk(8'((p ? 32 : 16) >> (3 - s)), 8'(t), 1);
      end
    end
    // every mode: pin roles, gain, start-up hold and wake
    for (int m = 0; m < 8; m++) begin
      do_reset(m[2:0], m[0]);
      idle(3);
      pins(m[2:0], m < 3);
      idle(60);
      pins(m[2:0], 1'b0);
      bus(1'b0, 1'b1, 4'h1, 8'h0, {4'h1, m[0], m[2:0]});
      config_mode <= ~m[2:0];
      bus(1'b0, 1'b1, 4'h1, 8'h0, {4'h1, m[0], m[2:0]});
      wake_event <= 1'b1;
      idle(0);
      wake_event <= 1'b0;
      idle(1);
      pins(m[2:0], m < 3);
    end
    idle(2);
    end_sim();
  end
endmodule
bind scs_clock_select scs_clock_select_props #(.OST_CYCLES(OST_CYCLES)) i_props (.clk,
  .resetn, .osc_lock_status, .osc_stable_status, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .sys_clk_src_int, .amp_gain, .osc_out_pin_oe, .osc_in_pin_gpio,
  .osc_out_pin_gpio, .device_hold_reset);
`default_nettype wire
